/* crf_cfg.svh */
// Purpose: Named constants for the CPU control-register block
// Assumes: Included by crf_core_regs.sv; crf_pkg.sv does not include it
// Notes: Bit positions of the float status word are local choices
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH

// Data path width
`define CRF_XLEN 32
// Index of the general register that doubles as stack pointer
`define CRF_SP_INDEX 4'h0
// Stack select bit in the processor status word (0 = interrupt SP)
`define CRF_STATUS_U_BIT 17
// Reset values
`define CRF_PC_RESET 32'h0000_0000
`define CRF_REG_RESET 32'h0000_0000
// Float status word layout
`define CRF_FP_NUM 5
`define CRF_FP_CAUSE_LSB 2
`define CRF_FP_ENABLE_LSB 10
`define CRF_FP_FLAG_LSB 26
// Vector table entries are one word apart
`define CRF_VEC_PAD 2'h0

`endif

/* crf_pkg.sv */
// Purpose: Types shared by the CPU control-register block
// Assumes: Widths match crf_cfg.svh; nothing is included here
// Notes: Select codes address the control registers on the side ports
package crf_pkg;

	// Control register selector for the write and read ports
	typedef enum logic [3:0] {
		CRF_SEL_IRQ_STACK = 4'b0000,
		CRF_SEL_USER_STACK = 4'b0001,
		CRF_SEL_VEC_BASE = 4'b0010,
		CRF_SEL_PC = 4'b0011,
		CRF_SEL_STATUS = 4'b0100,
		CRF_SEL_BAK_PC = 4'b0101,
		CRF_SEL_BAK_STATUS = 4'b0110,
		CRF_SEL_FAST_VEC = 4'b0111,
		CRF_SEL_FLOAT_STATUS = 4'b1000
	} crf_ctl_sel_t;

	// Floating-point exception bit order: X, U, Z, O, V from bit 0 up
	typedef logic [4:0] crf_fp_bits_t;

endpackage

/* crf_core_regs.sv */
// Purpose: General and control registers of a 32-bit core, fast irq path
// Assumes: One clock, synchronous active-high reset, same-domain inputs
// Notes: Register reads are registered; one cycle from select to data
// What this block does
// - Sixteen 32-bit general registers; register zero is stack pointer.
// - Stack pointer accesses go to interrupt or user SP by status bit.
// - Vector table start address comes from the vector base register.
// - Program counter holds the address of the executing instruction.
// - Fast interrupt copies program counter into backup program counter.
// - Fast interrupt copies status word into backup status, same layout.
// - Fast interrupt branches to address in fast irq vector register.
// - Enabled float exceptions raise an exception and set cause flags.
// - Masked float exceptions set cause and the matching accumulated flag only.
// - Accumulated float flags stay set until software writes zero.
`include "crf_cfg.svh"

module crf_core_regs (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// General register write port
	input wire logic gprWrEn,
	input wire logic [3:0] gprWrAddr,
	input wire logic [31:0] gprWrData,
	// General register read port
	input wire logic [3:0] gprRdAddr,
	output logic [31:0] gprRdData,
	// Control register write port
	input wire logic ctlWrEn,
	input wire crf_pkg::crf_ctl_sel_t ctlWrSel,
	input wire logic [31:0] ctlWrData,
	// Control register read port
	input wire crf_pkg::crf_ctl_sel_t ctlRdSel,
	output logic [31:0] ctlRdData,
	// Instruction sequencing
	input wire logic pcLoadEn,
	input wire logic [31:0] pcLoadValue,
	output logic [31:0] programCounter,
	output logic [31:0] processorStatusWord,
	// Fast interrupt entry and return
	input wire logic fastIrqTake,
	input wire logic fastIrqReturn,
	// Vector table lookup
	input wire logic vecLookup,
	input wire logic [7:0] vecNumber,
	output logic [31:0] vectorEntryAddr,
	// Floating-point result reporting
	input wire logic fpuResultValid,
	input wire crf_pkg::crf_fp_bits_t fpuExcFlags,
	output logic fpExceptionRaise,
	output crf_pkg::crf_fp_bits_t floatExceptionCause,
	output crf_pkg::crf_fp_bits_t floatStickyFlag
);

	// Register state
	logic [31:0] gprMem_reg [1:15];
	logic [31:0] interruptStackPointer_reg;
	logic [31:0] userStackPointer_reg;
	logic [31:0] vectorTableBase_reg;
	logic [31:0] programCounter_reg;
	logic [31:0] processorStatusWord_reg;
	logic [31:0] backupProgramCounter_reg;
	logic [31:0] backupStatusWord_reg;
	logic [31:0] fastIrqVector_reg;
	crf_pkg::crf_fp_bits_t floatExceptionEnable_reg;
	crf_pkg::crf_fp_bits_t floatExceptionCause_reg;
	crf_pkg::crf_fp_bits_t floatStickyFlag_reg;
	logic fpExceptionRaise_reg;
	logic [31:0] gprRdData_reg;
	logic [31:0] ctlRdData_reg;
	logic [31:0] vectorEntryAddr_reg;

	// Derived control
	logic userStackSel;
	logic spWrite;
	logic [31:0] activeStackPointer;
	logic [31:0] floatStatusWord;
	logic [31:0] statusFastEntry;
	logic floatStatusWrite;
	crf_pkg::crf_fp_bits_t fpStickySet;

	// Stack select decoding; register zero never has storage of its own
	assign userStackSel = processorStatusWord_reg[`CRF_STATUS_U_BIT];
	assign spWrite = gprWrEn && (gprWrAddr == `CRF_SP_INDEX);
	assign activeStackPointer = userStackSel ? userStackPointer_reg :
		interruptStackPointer_reg;
	assign floatStatusWrite = ctlWrEn &&
		(ctlWrSel == crf_pkg::CRF_SEL_FLOAT_STATUS);
	assign fpStickySet = fpuResultValid ?
		(fpuExcFlags & ~floatExceptionEnable_reg) : 5'h00;

	// Entry status: stack switches to the interrupt pointer in the handler
	always_comb begin
		statusFastEntry = processorStatusWord_reg;
		statusFastEntry[`CRF_STATUS_U_BIT] = 1'b0;
	end

	// Float status word image for reads
	always_comb begin
		floatStatusWord = `CRF_REG_RESET;
		floatStatusWord[`CRF_FP_CAUSE_LSB +: `CRF_FP_NUM] =
			floatExceptionCause_reg;
		floatStatusWord[`CRF_FP_ENABLE_LSB +: `CRF_FP_NUM] =
			floatExceptionEnable_reg;
		floatStatusWord[`CRF_FP_FLAG_LSB +: `CRF_FP_NUM] = floatStickyFlag_reg;
	end

	// General registers one to fifteen, one writer each
	for (genvar g = 1; g < 16; g++) begin : gGpr
		always_ff @(posedge clock) begin
			if (rst) begin
				gprMem_reg[g] <= `CRF_REG_RESET;
			end else if (gprWrEn && (gprWrAddr == 4'(g))) begin
				gprMem_reg[g] <= gprWrData;
			end
		end
	end

	// Interrupt stack pointer; control port wins over a same-cycle push
	always_ff @(posedge clock) begin
		if (rst) begin
			interruptStackPointer_reg <= `CRF_REG_RESET;
		end else if (ctlWrEn && (ctlWrSel == crf_pkg::CRF_SEL_IRQ_STACK)) begin
			interruptStackPointer_reg <= ctlWrData;
		end else if (spWrite && !userStackSel) begin
			interruptStackPointer_reg <= gprWrData;
		end
	end

	// User stack pointer; alignment is left to software
	always_ff @(posedge clock) begin
		if (rst) begin
			userStackPointer_reg <= `CRF_REG_RESET;
		end else if (ctlWrEn && (ctlWrSel == crf_pkg::CRF_SEL_USER_STACK)) begin
			userStackPointer_reg <= ctlWrData;
		end else if (spWrite && userStackSel) begin
			userStackPointer_reg <= gprWrData;
		end
	end

	// Vector base and fast vector, written by software only
	always_ff @(posedge clock) begin
		if (rst) begin
			vectorTableBase_reg <= `CRF_REG_RESET;
			fastIrqVector_reg <= `CRF_REG_RESET;
		end else if (ctlWrEn) begin
			if (ctlWrSel == crf_pkg::CRF_SEL_VEC_BASE) begin
				vectorTableBase_reg <= ctlWrData;
			end else if (ctlWrSel == crf_pkg::CRF_SEL_FAST_VEC) begin
				fastIrqVector_reg <= ctlWrData;
			end
		end
	end

	// Program counter: fast entry, then return, then software, then fetch
	always_ff @(posedge clock) begin
		if (rst) begin
			programCounter_reg <= `CRF_PC_RESET;
		end else if (fastIrqTake) begin
			programCounter_reg <= fastIrqVector_reg;
		end else if (fastIrqReturn) begin
			programCounter_reg <= backupProgramCounter_reg;
		end else if (ctlWrEn && (ctlWrSel == crf_pkg::CRF_SEL_PC)) begin
			programCounter_reg <= ctlWrData;
		end else if (pcLoadEn) begin
			programCounter_reg <= pcLoadValue;
		end
	end

	// Status word follows the same priority as the program counter
	always_ff @(posedge clock) begin
		if (rst) begin
			processorStatusWord_reg <= `CRF_REG_RESET;
		end else if (fastIrqTake) begin
			processorStatusWord_reg <= statusFastEntry;
		end else if (fastIrqReturn) begin
			processorStatusWord_reg <= backupStatusWord_reg;
		end else if (ctlWrEn && (ctlWrSel == crf_pkg::CRF_SEL_STATUS)) begin
			processorStatusWord_reg <= ctlWrData;
		end
	end

	// Backup pair; no stack traffic on fast entry, so nesting is not saved
	always_ff @(posedge clock) begin
		if (rst) begin
			backupProgramCounter_reg <= `CRF_REG_RESET;
			backupStatusWord_reg <= `CRF_REG_RESET;
		end else if (fastIrqTake) begin
			backupProgramCounter_reg <= programCounter_reg;
			backupStatusWord_reg <= processorStatusWord_reg;
		end else if (ctlWrEn && (ctlWrSel == crf_pkg::CRF_SEL_BAK_PC)) begin
			backupProgramCounter_reg <= ctlWrData;
		end else if (ctlWrEn && (ctlWrSel == crf_pkg::CRF_SEL_BAK_STATUS)) begin
			backupStatusWord_reg <= ctlWrData;
		end
	end

	// Float enables and causes; a result overrides a same-cycle cause write
	always_ff @(posedge clock) begin
		if (rst) begin
			floatExceptionEnable_reg <= 5'h00;
			floatExceptionCause_reg <= 5'h00;
		end else begin
			if (floatStatusWrite) begin
				floatExceptionEnable_reg <=
					ctlWrData[`CRF_FP_ENABLE_LSB +: `CRF_FP_NUM];
			end
			if (fpuResultValid) begin
				floatExceptionCause_reg <= fpuExcFlags;
			end else if (floatStatusWrite) begin
				floatExceptionCause_reg <=
					ctlWrData[`CRF_FP_CAUSE_LSB +: `CRF_FP_NUM];
			end
		end
	end

	// Sticky flags: hardware set beats a software clear in the same cycle
	for (genvar j = 0; j < `CRF_FP_NUM; j++) begin : gSticky
		always_ff @(posedge clock) begin
			if (rst) begin
				floatStickyFlag_reg[j] <= 1'b0;
			end else if (fpStickySet[j]) begin
				floatStickyFlag_reg[j] <= 1'b1;
			end else if (floatStatusWrite) begin
				floatStickyFlag_reg[j] <= ctlWrData[`CRF_FP_FLAG_LSB + j];
			end
		end
	end

	// Exception request pulse, one cycle after an enabled occurrence
	always_ff @(posedge clock) begin
		if (rst) begin
			fpExceptionRaise_reg <= 1'b0;
		end else begin
			fpExceptionRaise_reg <= fpuResultValid &&
				((fpuExcFlags & floatExceptionEnable_reg) != 5'h00);
		end
	end

	// Vector entry address; base is used as given, alignment is software's
	always_ff @(posedge clock) begin
		if (rst) begin
			vectorEntryAddr_reg <= `CRF_REG_RESET;
		end else if (vecLookup) begin
			vectorEntryAddr_reg <= vectorTableBase_reg +
				{22'h000000, vecNumber, `CRF_VEC_PAD};
		end
	end

	// General register read, zero maps to the active stack pointer
	always_ff @(posedge clock) begin
		if (rst) begin
			gprRdData_reg <= `CRF_REG_RESET;
		end else if (gprRdAddr == `CRF_SP_INDEX) begin
			gprRdData_reg <= activeStackPointer;
		end else begin
			gprRdData_reg <= gprMem_reg[gprRdAddr];
		end
	end

	// Control register read; unused selects read as zero
	always_ff @(posedge clock) begin
		if (rst) begin
			ctlRdData_reg <= `CRF_REG_RESET;
		end else begin
			case (ctlRdSel)
				crf_pkg::CRF_SEL_IRQ_STACK:
					ctlRdData_reg <= interruptStackPointer_reg;
				crf_pkg::CRF_SEL_USER_STACK: ctlRdData_reg <= userStackPointer_reg;
				crf_pkg::CRF_SEL_VEC_BASE: ctlRdData_reg <= vectorTableBase_reg;
				crf_pkg::CRF_SEL_PC: ctlRdData_reg <= programCounter_reg;
				crf_pkg::CRF_SEL_STATUS: ctlRdData_reg <= processorStatusWord_reg;
				crf_pkg::CRF_SEL_BAK_PC:
					ctlRdData_reg <= backupProgramCounter_reg;
				crf_pkg::CRF_SEL_BAK_STATUS: ctlRdData_reg <= backupStatusWord_reg;
				crf_pkg::CRF_SEL_FAST_VEC: ctlRdData_reg <= fastIrqVector_reg;
				crf_pkg::CRF_SEL_FLOAT_STATUS: ctlRdData_reg <= floatStatusWord;
				default: ctlRdData_reg <= `CRF_REG_RESET;
			endcase
		end
	end

	// Outputs, all straight from flip-flops
	assign gprRdData = gprRdData_reg;
	assign ctlRdData = ctlRdData_reg;
	assign programCounter = programCounter_reg;
	assign processorStatusWord = processorStatusWord_reg;
	assign vectorEntryAddr = vectorEntryAddr_reg;
	assign fpExceptionRaise = fpExceptionRaise_reg;
	assign floatExceptionCause = floatExceptionCause_reg;
	assign floatStickyFlag = floatStickyFlag_reg;

	// Checks, all on the core clock
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	a_sp_user_route: assert property (
		spWrite && userStackSel && !ctlWrEn |=>
		userStackPointer_reg == $past(gprWrData) &&
		interruptStackPointer_reg == $past(interruptStackPointer_reg))
		else $error("user stack write misrouted");

	a_sp_isp_route: assert property (
		spWrite && !userStackSel && !ctlWrEn |=>
		interruptStackPointer_reg == $past(gprWrData) &&
		userStackPointer_reg == $past(userStackPointer_reg))
		else $error("interrupt stack write misrouted");

	a_gpr_readback: assert property (
		gprWrEn && gprWrAddr != `CRF_SP_INDEX && !spWrite ##1
		(gprRdAddr == $past(gprWrAddr) && !gprWrEn) |=>
		gprRdData == $past(gprWrData, 2))
		else $error("general register readback wrong");

	a_fast_entry_pc: assert property (
		fastIrqTake |=> backupProgramCounter_reg == $past(programCounter_reg)
		&& programCounter_reg == $past(fastIrqVector_reg))
		else $error("fast entry pc save or branch wrong");

	a_fast_entry_psw: assert property (
		fastIrqTake |=> backupStatusWord_reg == $past(processorStatusWord_reg)
		&& !processorStatusWord_reg[`CRF_STATUS_U_BIT])
		else $error("fast entry status save wrong");

	a_fast_return: assert property (
		fastIrqReturn && !fastIrqTake |=>
		programCounter_reg == $past(backupProgramCounter_reg) &&
		processorStatusWord_reg == $past(backupStatusWord_reg))
		else $error("fast return restore wrong");

	a_pc_follow: assert property (
		pcLoadEn && !fastIrqTake && !fastIrqReturn && !ctlWrEn |=>
		programCounter_reg == $past(pcLoadValue))
		else $error("program counter did not follow fetch");

	a_vec_address: assert property (
		vecLookup && !ctlWrEn |=> vectorEntryAddr_reg ==
		$past(vectorTableBase_reg) + {22'h000000, $past(vecNumber), 2'h0})
		else $error("vector entry address wrong");

	a_fp_raise: assert property (
		fpuResultValid |=> fpExceptionRaise_reg ==
		(($past(fpuExcFlags) & $past(floatExceptionEnable_reg)) != 5'h00)
		&& floatExceptionCause_reg == $past(fpuExcFlags))
		else $error("float exception raise or cause wrong");

	a_fp_sticky_set: assert property (
		fpStickySet != 5'h00 |=>
		(floatStickyFlag_reg & $past(fpStickySet)) == $past(fpStickySet))
		else $error("masked float exception not recorded");

	a_fp_sticky_hold: assert property (
		!floatStatusWrite |=>
		($past(floatStickyFlag_reg) & ~floatStickyFlag_reg) == 5'h00)
		else $error("sticky float flag dropped without write");

	// Main scenarios
	c_fast_round_trip: cover property (fastIrqTake ##[1:20] fastIrqReturn);
	c_fp_raise: cover property (fpExceptionRaise_reg);
	c_fp_set_vs_clear: cover property (floatStatusWrite &&
		fpStickySet != 5'h00);
	c_user_stack_push: cover property (spWrite && userStackSel);

endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the CPU control-register block
// Assumes: Inputs change 1 ns after the rising edge; reads are registered
// Notes: Fixed latencies only, so no scenario waits on a handshake
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// Clock and reset
	logic clock;
	logic rst;
	// Register ports
	logic gprWrEn;
	logic [3:0] gprWrAddr;
	logic [31:0] gprWrData;
	logic [3:0] gprRdAddr;
	logic [31:0] gprRdData;
	logic ctlWrEn;
	crf_pkg::crf_ctl_sel_t ctlWrSel;
	logic [31:0] ctlWrData;
	crf_pkg::crf_ctl_sel_t ctlRdSel;
	logic [31:0] ctlRdData;
	// Sequencing, fast irq and vectors
	logic pcLoadEn;
	logic [31:0] pcLoadValue;
	logic [31:0] programCounter;
	logic [31:0] processorStatusWord;
	logic fastIrqTake;
	logic fastIrqReturn;
	logic vecLookup;
	logic [7:0] vecNumber;
	logic [31:0] vectorEntryAddr;
	// Float reporting
	logic fpuResultValid;
	crf_pkg::crf_fp_bits_t fpuExcFlags;
	logic fpExceptionRaise;
	crf_pkg::crf_fp_bits_t floatExceptionCause;
	crf_pkg::crf_fp_bits_t floatStickyFlag;
	int numErrors;
	int cmpCount;
	logic [31:0] rd;

	crf_core_regs crf_core_regs_i (.clock(clock), .rst(rst),
		.gprWrEn(gprWrEn), .gprWrAddr(gprWrAddr), .gprWrData(gprWrData),
		.gprRdAddr(gprRdAddr), .gprRdData(gprRdData),
		.ctlWrEn(ctlWrEn), .ctlWrSel(ctlWrSel), .ctlWrData(ctlWrData),
		.ctlRdSel(ctlRdSel), .ctlRdData(ctlRdData),
		.pcLoadEn(pcLoadEn), .pcLoadValue(pcLoadValue),
		.programCounter(programCounter),
		.processorStatusWord(processorStatusWord),
		.fastIrqTake(fastIrqTake), .fastIrqReturn(fastIrqReturn),
		.vecLookup(vecLookup), .vecNumber(vecNumber),
		.vectorEntryAddr(vectorEntryAddr),
		.fpuResultValid(fpuResultValid), .fpuExcFlags(fpuExcFlags),
		.fpExceptionRaise(fpExceptionRaise),
		.floatExceptionCause(floatExceptionCause),
		.floatStickyFlag(floatStickyFlag));

	// Free-running core clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// One edge passes, then inputs move off the sampling edge
	task automatic step;
		@(posedge clock);
		#1;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		cmpCount++;
		if (seen !== exp) begin
			numErrors++;
			$display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Write helpers; an idle edge follows so strobes never re-rise at once
	task automatic ctlWrite(input crf_pkg::crf_ctl_sel_t s, input logic [31:0] d);
		ctlWrEn = 1'b1;
		ctlWrSel = s;
		ctlWrData = d;
		step();
		ctlWrEn = 1'b0;
		step();
	endtask

	task automatic ctlRead(input crf_pkg::crf_ctl_sel_t s, output logic [31:0] d);
		ctlRdSel = s;
		step();
		d = ctlRdData;
	endtask

	task automatic gprWrite(input logic [3:0] a, input logic [31:0] d);
		gprWrEn = 1'b1;
		gprWrAddr = a;
		gprWrData = d;
		step();
		gprWrEn = 1'b0;
		step();
	endtask

	task automatic gprRead(input logic [3:0] a, output logic [31:0] d);
		gprRdAddr = a;
		step();
		d = gprRdData;
	endtask

	task automatic fpResult(input crf_pkg::crf_fp_bits_t f);
		fpuResultValid = 1'b1;
		fpuExcFlags = f;
		step();
		fpuResultValid = 1'b0;
	endtask

	// General registers and stack pointer steering
	task automatic test_gpr;
		gprWrite(4'h5, 32'hA5A5_0005);
		gprWrite(4'hF, 32'h5A5A_000F);
		gprRead(4'h5, rd);
		check(rd, 32'hA5A5_0005, "gpr 5");
		gprRead(4'hF, rd);
		check(rd, 32'h5A5A_000F, "gpr 15");
		gprWrite(4'h0, 32'h0000_1000);
		ctlRead(crf_pkg::CRF_SEL_IRQ_STACK, rd);
		check(rd, 32'h0000_1000, "sp to irq stack");
		ctlWrite(crf_pkg::CRF_SEL_STATUS, 32'h0002_0000);
		gprWrite(4'h0, 32'h0000_2000);
		ctlRead(crf_pkg::CRF_SEL_USER_STACK, rd);
		check(rd, 32'h0000_2000, "sp to user stack");
		gprRead(4'h0, rd);
		check(rd, 32'h0000_2000, "sp reads user stack");
		ctlWrite(crf_pkg::CRF_SEL_STATUS, 32'h0000_0000);
		gprRead(4'h0, rd);
		check(rd, 32'h0000_1000, "sp reads irq stack");
	endtask

	// Vector table address at both ends of the number range
	task automatic test_vector;
		ctlWrite(crf_pkg::CRF_SEL_VEC_BASE, 32'h0000_4000);
		vecLookup = 1'b1;
		vecNumber = 8'hFF;
		step();
		check(vectorEntryAddr, 32'h0000_43FC, "vector 255");
		vecNumber = 8'h00;
		step();
		vecLookup = 1'b0;
		check(vectorEntryAddr, 32'h0000_4000, "vector 0");
	endtask

	// Fast entry with a return request in the same cycle, then return
	task automatic test_fast;
		ctlWrite(crf_pkg::CRF_SEL_FAST_VEC, 32'h0000_8000);
		ctlWrite(crf_pkg::CRF_SEL_STATUS, 32'h0002_0000);
		pcLoadEn = 1'b1;
		pcLoadValue = 32'h0000_1234;
		step();
		pcLoadEn = 1'b0;
		check(programCounter, 32'h0000_1234, "pc load");
		fastIrqTake = 1'b1;
		fastIrqReturn = 1'b1;
		step();
		fastIrqTake = 1'b0;
		fastIrqReturn = 1'b0;
		check(programCounter, 32'h0000_8000, "fast branch");
		check(processorStatusWord, 32'h0000_0000, "entry status");
		ctlRead(crf_pkg::CRF_SEL_BAK_PC, rd);
		check(rd, 32'h0000_1234, "backup pc");
		ctlRead(crf_pkg::CRF_SEL_BAK_STATUS, rd);
		check(rd, 32'h0002_0000, "backup status");
		fastIrqReturn = 1'b1;
		step();
		fastIrqReturn = 1'b0;
		check(programCounter, 32'h0000_1234, "return pc");
		check(processorStatusWord, 32'h0002_0000, "return status");
		ctlWrite(crf_pkg::CRF_SEL_STATUS, 32'h0000_0000);
	endtask

	// Masked flags accumulate, survive, clear; enabled one raises
	task automatic test_float;
		for (int j = 0; j < 5; j++) begin
			fpResult(5'(1 << j));
			check(32'(fpExceptionRaise), 32'h0, "masked raise");
			check(32'(floatStickyFlag), 32'((2 << j) - 1), "sticky");
			check(32'(floatExceptionCause), 32'(1 << j), "cause");
			step();
		end
		fpResult(5'h00);
		check(32'(floatStickyFlag), 32'h1F, "sticky held");
		ctlWrite(crf_pkg::CRF_SEL_FLOAT_STATUS, 32'h0000_1000);
		check(32'(floatStickyFlag), 32'h00, "sticky cleared");
		fpResult(5'h05);
		check(32'(fpExceptionRaise), 32'h1, "raise");
		check(32'(floatExceptionCause), 32'h05, "cause both");
		check(32'(floatStickyFlag), 32'h01, "sticky masked");
		ctlRead(crf_pkg::CRF_SEL_FLOAT_STATUS, rd);
		check(32'(fpExceptionRaise), 32'h0, "raise one cycle");
		check(rd, 32'h0400_1014, "float status image");
	endtask

	// Guard against a hung run
	initial begin
		repeat (5000) @(posedge clock);
		numErrors++;
		$display("ERROR %0t run limit reached", $time);
		summarize();
	end

	// Main sequence: all inputs defined at time zero
	initial begin
		numErrors = 0;
		cmpCount = 0;
		rst = 1'b1;
		gprWrEn = 1'b0;
		gprWrAddr = 4'h0;
		gprWrData = 32'h0000_0000;
		gprRdAddr = 4'h0;
		ctlWrEn = 1'b0;
		ctlWrSel = crf_pkg::CRF_SEL_IRQ_STACK;
		ctlWrData = 32'h0000_0000;
		ctlRdSel = crf_pkg::CRF_SEL_IRQ_STACK;
		pcLoadEn = 1'b0;
		pcLoadValue = 32'h0000_0000;
		fastIrqTake = 1'b0;
		fastIrqReturn = 1'b0;
		vecLookup = 1'b0;
		vecNumber = 8'h00;
		fpuResultValid = 1'b0;
		fpuExcFlags = 5'h00;
		repeat (12) step();
		rst = 1'b0;
		check(programCounter, 32'h0000_0000, "reset pc");
		check(32'(floatStickyFlag), 32'h0, "reset sticky");
		test_gpr();
		test_vector();
		test_fast();
		test_float();
		summarize();
	end
endmodule
